// ==== hdl/fbo_top.sv ====
// Purpose: fail-safe fallback output control with pulsed companions
// Assumes: mode and event inputs come from logic on clk; supply
//          comparators and the strap pin are asynchronous
// Notes:   pins are open drain; an _oe_n low means the pin is pulled low
//
// Operation
// R1 - main fallback output is open drain, pulled low when active.
// R2 - activation comes from a failure condition or an SPI command.
// R3 - below the minimum supply threshold the fallback stays released.
// R4 - turn signal pulses only while the fallback output is active.
// R5 - shared dimming/strap pin is an input in init mode only.
// R6 - dimming pulse is low 20 percent, released 80 percent.
// R7 - dimming drive is inhibited during init mode.
// R8 - strap held at ground selects software development mode.
// R9 - strap pull-up is enabled only in init mode.
// R10 - development mode needs strap low for the whole init interval.
// R11 - development mode is kept until the chip goes off.
// R12 - normal mode: off unless SPI on; earlier activation persists.
// R13 - init forces off, fail-safe forces on, other modes keep state.
// R14 - watchdog failures trigger activation: first or second by config.
// R15 - restart mode: reset short or regulator undervoltage timeout activates.
// R16 - init timeout and regulator thermal shutdown activate in any mode.
// R17 - SPI activation from normal mode persists across modes.
// R18 - SPI activation clears only on an SPI release command.
// R19 - fault release needs restart, normal, good watchdog, SPI release.
// R20 - turn signal runs at 1.25 Hz.
// R21 - turn signal duty is 50 percent low.
// R22 - dimming pulse runs at 100 Hz.
// R23 - waveforms divide the oscillator and start low on activation.

`timescale 1ns/10ps

module fbo_top #(
    parameter int unsigned TURN_PERIOD_CYC = fbo_pkg::TURN_PERIOD_CYC,
    parameter int unsigned DIM_PERIOD_CYC = fbo_pkg::DIM_PERIOD_CYC
) (
    input wire logic clk,                        // 200 MHz oscillator
    input wire logic nrst,                       // power-off reset
    input wire fbo_pkg::fbo_mode_t chip_mode,    // current chip mode
    input wire logic supply_fb_ok,               // above fallback minimum
    input wire logic supply_pwr_ok,              // above power-off level
    input wire logic wd_fail,                    // watchdog failure pulse
    input wire logic wd_trigger_ok,              // good watchdog pulse
    input wire logic cfg_second_fail,            // config 3/4 selected
    input wire logic reset_short_supply,         // reset clamped high
    input wire logic reset_short_gnd,            // reset clamped low
    input wire logic main_uv_timeout,            // regulator uv timeout
    input wire logic init_timeout,               // init mode timed out
    input wire logic main_thermal_sd,            // regulator thermal off
    input wire logic spi_activate,               // SPI activation pulse
    input wire logic spi_release,                // SPI release pulse
    input wire logic strap_pin_i,                // shared pin level
    output logic fallback_output_o,              // pin level when driven
    output logic fallback_output_oe_n,           // low pulls pin low
    output logic turn_signal_pulse_output_o,     // pin level when driven
    output logic turn_signal_pulse_output_oe_n,  // low pulls pin low
    output logic dimming_pulse_output_o,         // pin level when driven
    output logic dimming_pulse_output_oe_n,      // low pulls pin low
    output logic strap_pullup_en,                // internal pull-up on
    output logic sw_dev_mode,                    // development mode held
    output logic fallback_active                 // fallback state
);

    // ---------------------------------------------------------------------
    // reset release
    // ---------------------------------------------------------------------
    logic rst_q1;
    logic rst_n;

    // assert at once, release through two flops
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rst_q1 <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_q1 <= 1'b1;
            rst_n <= rst_q1;
        end
    end

    // ---------------------------------------------------------------------
    // input synchronisers
    // ---------------------------------------------------------------------
    logic [2:0] async_s;
    logic fb_supply_s;
    logic pwr_supply_s;
    logic strap_s;

    // strap idles high, matching the pull-up; supplies idle low
    fbo_sync #(
        .WIDTH(3),
        .RST_VAL(3'h4)
    ) u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .din({strap_pin_i, supply_pwr_ok, supply_fb_ok}),
        .dout(async_s)
    );

    assign fb_supply_s = async_s[0];
    assign pwr_supply_s = async_s[1];
    assign strap_s = async_s[2];

    // ---------------------------------------------------------------------
    // mode decode
    // ---------------------------------------------------------------------
    logic in_init;
    logic in_normal;
    logic in_restart;
    logic in_fail_safe;
    logic in_off;

    function automatic logic is_mode(input fbo_pkg::fbo_mode_t m,
                                     input fbo_pkg::fbo_mode_t ref_m);
        is_mode = (m == ref_m);
    endfunction

    assign in_init = is_mode(chip_mode, fbo_pkg::MODE_INIT);
    assign in_normal = is_mode(chip_mode, fbo_pkg::MODE_NORMAL);
    assign in_restart = is_mode(chip_mode, fbo_pkg::MODE_RESTART);
    assign in_fail_safe = is_mode(chip_mode, fbo_pkg::MODE_FAIL_SAFE);
    assign in_off = is_mode(chip_mode, fbo_pkg::MODE_OFF);

    // ---------------------------------------------------------------------
    // SPI commanded activation
    // ---------------------------------------------------------------------
    logic spi_hold_q;
    logic spi_set;

    // only accepted in normal mode
    assign spi_set = spi_activate && in_normal; // [R12]

    // set wins over release; survives every later mode change
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            spi_hold_q <= 1'b0;
        end else if (spi_set) begin
            spi_hold_q <= 1'b1; // [R17]
        end else if (spi_release) begin
            spi_hold_q <= 1'b0; // [R18]
        end
    end

    // ---------------------------------------------------------------------
    // watchdog failure count
    // ---------------------------------------------------------------------
    logic [1:0] wd_cnt_q;
    logic [1:0] wd_cnt_d;
    logic [1:0] wd_limit;
    logic wd_trip;

    assign wd_limit = cfg_second_fail ? fbo_pkg::WD_FAILS_CFG34
                                      : fbo_pkg::WD_FAILS_CFG12;

    // saturating count of failures seen in normal mode
    always_comb begin
        wd_cnt_d = wd_cnt_q;
        if (wd_fail && in_normal && wd_cnt_q != 2'h3) begin
            wd_cnt_d = wd_cnt_q + 2'h1;
        end
    end

    assign wd_trip = wd_fail && in_normal && (wd_cnt_d >= wd_limit); // [R14]

    // a good trigger starts the count over
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wd_cnt_q <= 2'h0;
        end else if (wd_trigger_ok && !wd_fail) begin
            wd_cnt_q <= 2'h0;
        end else begin
            wd_cnt_q <= wd_cnt_d;
        end
    end

    // ---------------------------------------------------------------------
    // fault events
    // ---------------------------------------------------------------------
    logic fault_evt;

    // restart faults count only in restart mode; thermal and init anywhere
    assign fault_evt = wd_trip
        || (in_restart && (reset_short_supply || reset_short_gnd
                           || main_uv_timeout)) // [R15]
        || init_timeout || main_thermal_sd      // [R16]
        || in_fail_safe;                        // [R13]

    // ---------------------------------------------------------------------
    // release sequence
    // ---------------------------------------------------------------------
    fbo_pkg::fbo_rel_t rel_q;
    fbo_pkg::fbo_rel_t rel_d;

    // a new fault always wins over any step of the release
    always_comb begin
        rel_d = rel_q;
        case (rel_q)
            fbo_pkg::REL_IDLE: begin
                rel_d = fbo_pkg::REL_IDLE;
            end
            fbo_pkg::REL_FAULT: begin
                if (in_restart) begin
                    rel_d = fbo_pkg::REL_RESTARTED; // [R19]
                end
            end
            fbo_pkg::REL_RESTARTED: begin
                if (in_normal && wd_trigger_ok) begin
                    rel_d = fbo_pkg::REL_ARMED; // [R19]
                end
            end
            fbo_pkg::REL_ARMED: begin
                if (in_restart) begin
                    rel_d = fbo_pkg::REL_RESTARTED;
                end else if (in_normal && spi_release) begin
                    rel_d = fbo_pkg::REL_IDLE; // [R19]
                end
            end
            default: begin
                rel_d = fbo_pkg::REL_FAULT;
            end
        endcase
        if (in_init) begin
            rel_d = fbo_pkg::REL_IDLE; // [R13]
        end
        if (fault_evt) begin
            rel_d = fbo_pkg::REL_FAULT; // [R2]
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rel_q <= fbo_pkg::REL_IDLE;
        end else begin
            rel_q <= rel_d;
        end
    end

    // ---------------------------------------------------------------------
    // fallback activation
    // ---------------------------------------------------------------------
    logic active_q;
    logic request;

    // stop, sleep and flash simply keep the latches as they are
    assign request = spi_hold_q || (rel_q != fbo_pkg::REL_IDLE); // [R2]

    // supply too low or init mode keeps the stage released
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            active_q <= 1'b0;
        end else begin
            active_q <= request && fb_supply_s && !in_init; // [R3] [R13]
        end
    end

    // ---------------------------------------------------------------------
    // pulse waveforms
    // ---------------------------------------------------------------------
    logic turn_low;
    logic dim_low;

    function automatic int unsigned low_cycles(input int unsigned period,
                                               input int unsigned pct);
        int unsigned n;
        n = (period / 100) * pct;
        low_cycles = (n == 0) ? 1 : n;
    endfunction

    fbo_pulse_gen #(
        .PERIOD(TURN_PERIOD_CYC),                               // [R20]
        .LOW(low_cycles(TURN_PERIOD_CYC, fbo_pkg::TURN_LOW_PCT)) // [R21]
    ) u_turn (
        .clk(clk),
        .rst_n(rst_n),
        .en(active_q), // [R23]
        .low_phase(turn_low)
    );

    fbo_pulse_gen #(
        .PERIOD(DIM_PERIOD_CYC),                              // [R22]
        .LOW(low_cycles(DIM_PERIOD_CYC, fbo_pkg::DIM_LOW_PCT)) // [R6]
    ) u_dim (
        .clk(clk),
        .rst_n(rst_n),
        .en(active_q), // [R23]
        .low_phase(dim_low)
    );

    // ---------------------------------------------------------------------
    // pin drivers
    // ---------------------------------------------------------------------
    logic pin_level_q;

    // open drain stages only ever drive low
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_level_q <= fbo_pkg::RST_PIN_LEVEL;
        end else begin
            pin_level_q <= fbo_pkg::RST_PIN_LEVEL;
        end
    end

    assign fallback_output_o = pin_level_q;
    assign turn_signal_pulse_output_o = pin_level_q;
    assign dimming_pulse_output_o = pin_level_q;
    assign fallback_active = active_q;

    // enables registered; shared pin stays released in init for the strap
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fallback_output_oe_n <= 1'b1;
            turn_signal_pulse_output_oe_n <= 1'b1;
            dimming_pulse_output_oe_n <= 1'b1;
        end else begin
            fallback_output_oe_n <= !active_q; // [R1]
            turn_signal_pulse_output_oe_n <= !(active_q && turn_low); // [R4]
            dimming_pulse_output_oe_n <=
                !(active_q && dim_low && !in_init); // [R5] [R7]
        end
    end

    // ---------------------------------------------------------------------
    // strap sampling
    // ---------------------------------------------------------------------
    logic strap_low_q;
    logic init_seen_q;

    // pull-up only while the strap is being read
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            strap_pullup_en <= 1'b0;
        end else begin
            strap_pullup_en <= in_init; // [R9]
        end
    end

    // one high sample in init spoils the selection; off re-arms it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            strap_low_q <= fbo_pkg::RST_STRAP_LOW;
            init_seen_q <= 1'b0;
        end else if (in_off || !pwr_supply_s) begin
            strap_low_q <= fbo_pkg::RST_STRAP_LOW;
            init_seen_q <= 1'b0;
        end else if (in_init) begin
            init_seen_q <= 1'b1;
            if (strap_s) begin
                strap_low_q <= 1'b0; // [R10]
            end
        end
    end

    // latched at init exit, kept until the chip goes off
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sw_dev_mode <= 1'b0;
        end else if (in_off || !pwr_supply_s) begin
            sw_dev_mode <= 1'b0; // [R11]
        end else if (init_seen_q && !in_init && strap_low_q) begin
            sw_dev_mode <= 1'b1; // [R8]
        end
    end

    // ---------------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_rise;
        !active_q ##1 active_q;
    endsequence

    sequence s_spi_on;
        spi_activate && in_normal;
    endsequence

    a_low_supply_off: assert property ( // [R3]
        !fb_supply_s |=> !active_q)
        else $error("fallback active below minimum supply");

    a_pin_follows: assert property ( // [R1]
        ##1 fallback_output_oe_n == !$past(active_q))
        else $error("fallback pin does not follow activation");

    a_init_forces_off: assert property ( // [R13]
        in_init |=> !active_q ##1 dimming_pulse_output_oe_n)
        else $error("outputs not off in init mode");

    a_failsafe_on: assert property ( // [R13]
        in_fail_safe && fb_supply_s ##1 fb_supply_s && !in_init
        |=> active_q)
        else $error("fail-safe mode did not activate fallback");

    a_spi_hold_set: assert property ( // [R17]
        s_spi_on |=> spi_hold_q)
        else $error("SPI activation not held");

    a_spi_release: assert property ( // [R18]
        spi_release && !spi_set |=> !spi_hold_q)
        else $error("SPI release ignored");

    a_dim_inhibit: assert property ( // [R7]
        in_init |=> dimming_pulse_output_oe_n)
        else $error("dimming driven during init");

    a_pullup_init: assert property ( // [R9]
        ##1 strap_pullup_en == $past(in_init))
        else $error("strap pull-up outside init");

    a_turn_idle: assert property ( // [R4]
        !active_q |=> turn_signal_pulse_output_oe_n)
        else $error("turn signal pulses while inactive");

    a_thermal_trip: assert property ( // [R16]
        main_thermal_sd && !in_init |=> rel_q == fbo_pkg::REL_FAULT)
        else $error("thermal shutdown did not latch fault");

    a_first_low: assert property ( // [R23]
        s_rise ##0 !in_init |=> !turn_signal_pulse_output_oe_n
                   && !dimming_pulse_output_oe_n)
        else $error("waveform did not start low");

    a_armed_path: assert property ( // [R19]
        rel_q == fbo_pkg::REL_ARMED && $past(rel_q) != fbo_pkg::REL_ARMED
        |-> $past(rel_q) == fbo_pkg::REL_RESTARTED)
        else $error("release armed without restart");

endmodule

// ==== hdl/fbo_pkg.sv ====
// Purpose: shared constants and types for the fallback output controller
// Assumes: 200 MHz core clock from the internal chip oscillator
// Notes:   frequencies are held in hertz or hundredths of a hertz, cycles derived here

// ---------------------------------------------------------------------
// package
// ---------------------------------------------------------------------
package fbo_pkg;

    // clock rate
    localparam int unsigned CLK_FREQ_HZ = 200_000_000;

    // turn-signal frequency in hundredths of a hertz (1.25 Hz)
    localparam int unsigned TURN_FREQ_CHZ = 125;
    // dimming frequency in hertz
    localparam int unsigned DIM_FREQ_HZ = 100;

    // duty of the low portion, in percent
    localparam int unsigned TURN_LOW_PCT = 50;
    localparam int unsigned DIM_LOW_PCT = 20;

    // derived period counts; divide first to stay inside 32 bits
    localparam int unsigned TURN_PERIOD_CYC =
        (CLK_FREQ_HZ / TURN_FREQ_CHZ) * 100;
    localparam int unsigned DIM_PERIOD_CYC = CLK_FREQ_HZ / DIM_FREQ_HZ;

    // watchdog failures before automatic activation
    localparam logic [1:0] WD_FAILS_CFG12 = 2'h1;
    localparam logic [1:0] WD_FAILS_CFG34 = 2'h2;

    // reset values
    localparam logic RST_STRAP_LOW = 1'b1;
    localparam logic RST_PIN_LEVEL = 1'b0;

    // chip operating modes, gray coded along the power-up path
    typedef enum logic [2:0] {
        MODE_OFF       = 3'h0,
        MODE_INIT      = 3'h1,
        MODE_NORMAL    = 3'h3,
        MODE_STOP      = 3'h2,
        MODE_SLEEP     = 3'h6,
        MODE_RESTART   = 3'h7,
        MODE_FAIL_SAFE = 3'h5,
        MODE_FLASH     = 3'h4
    } fbo_mode_t;

    // release sequence of a fault-triggered activation
    typedef enum logic [1:0] {
        REL_IDLE      = 2'h0,
        REL_FAULT     = 2'h1,
        REL_RESTARTED = 2'h3,
        REL_ARMED     = 2'h2
    } fbo_rel_t;

endpackage

// ==== hdl/fbo_sync.sv ====
// Purpose: two-flop synchroniser for pin and comparator levels
// Assumes: inputs are slow levels, not pulses
// Notes:   first stage feeds only the second stage

`timescale 1ns/10ps

module fbo_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input wire logic clk,               // core clock
    input wire logic rst_n,             // synchronised reset, active low
    input wire logic [WIDTH-1:0] din,   // asynchronous levels
    output logic [WIDTH-1:0] dout       // synchronised levels
);

    logic [WIDTH-1:0] meta_q;

    // ---------------------------------------------------------------------
    // two stages
    // ---------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= RST_VAL;
            dout <= RST_VAL;
        end else begin
            meta_q <= din;
            dout <= meta_q;
        end
    end

endmodule

// ==== hdl/fbo_pulse_gen.sv ====
// Purpose: divider that produces a low/release waveform
// Assumes: period above low count, both at least one
// Notes:   held at phase zero while disabled, so each burst starts low

`timescale 1ns/10ps

module fbo_pulse_gen #(
    parameter int unsigned PERIOD = 100,
    parameter int unsigned LOW = 50
) (
    input wire logic clk,     // core clock
    input wire logic rst_n,   // synchronised reset, active low
    input wire logic en,      // run the waveform
    output logic low_phase    // high while the pin is to be pulled low
);

    logic [31:0] cnt_q;

    // ---------------------------------------------------------------------
    // period counter
    // ---------------------------------------------------------------------
    // restarting at zero on every enable keeps the first low slot full
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= 32'h0000_0000;
        end else if (!en || cnt_q == 32'(PERIOD - 1)) begin
            cnt_q <= 32'h0000_0000;
        end else begin
            cnt_q <= cnt_q + 32'h0000_0001;
        end
    end

    // low portion leads each period
    assign low_phase = en && (cnt_q < 32'(LOW));

endmodule

// ==== testbench/fbo_mcu_model.sv ====
// Purpose: microcontroller model issuing SPI and watchdog pulses
// Assumes: one request at a time, called from the bench
// Notes:   each pulse lasts one clock, launched at the falling edge
`timescale 1ns/10ps
module fbo_mcu_model (
    input wire logic clk,  // core clock
    output logic spi_on,   // SPI activation pulse
    output logic spi_off,  // SPI release pulse
    output logic wd_miss,  // watchdog failure pulse
    output logic wd_good   // good watchdog trigger pulse
);
    // -----------------------------------------------------------
    // requests
    // -----------------------------------------------------------
    initial begin
        {spi_on, spi_off, wd_miss, wd_good} = 4'h0;
    end
    // op 0 on, 1 release, 2 miss, 3 good trigger
    task automatic send(input logic [1:0] op);
        @(negedge clk);
        spi_on = (op == 2'h0);
        spi_off = (op == 2'h1);
        wd_miss = (op == 2'h2);
        wd_good = (op == 2'h3);
        @(negedge clk);
        {spi_on, spi_off, wd_miss, wd_good} = 4'h0;
    endtask
endmodule

// ==== testbench/testbench.sv ====
// Purpose: self-checking bench for the fallback output controller
// Assumes: short pulse periods of 200 and 100 cycles
// Notes:   open-drain pins are judged by their _oe_n, plus one check of the driven levels
`timescale 1ns/10ps
module testbench;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    fbo_pkg::fbo_mode_t md;
    logic fb_ok, pwr_ok, cfg2, strap;
    logic rs_s, rs_g, uv, ito, tsd;
    logic son, soff, wdf, wdg, fo, fn, to, tn, dmo, dn, pu, dev, act;
    int mismatches = 0, n_tests = 0, cyc = 0;
    // -----------------------------------------------------------
    // design and partner
    // -----------------------------------------------------------
    fbo_top #(.TURN_PERIOD_CYC(200), .DIM_PERIOD_CYC(100)) i_dut (
        .clk(clk), .nrst(nrst), .chip_mode(md), .supply_fb_ok(fb_ok),
        .supply_pwr_ok(pwr_ok), .wd_fail(wdf), .wd_trigger_ok(wdg),
        .cfg_second_fail(cfg2), .reset_short_supply(rs_s),
        .reset_short_gnd(rs_g), .main_uv_timeout(uv),
        .init_timeout(ito), .main_thermal_sd(tsd), .spi_activate(son),
        .spi_release(soff), .strap_pin_i(strap),
        .fallback_output_o(fo), .fallback_output_oe_n(fn),
        .turn_signal_pulse_output_o(to),
        .turn_signal_pulse_output_oe_n(tn),
        .dimming_pulse_output_o(dmo), .dimming_pulse_output_oe_n(dn),
        .strap_pullup_en(pu), .sw_dev_mode(dev), .fallback_active(act));
    fbo_mcu_model i_mcu (.clk(clk), .spi_on(son), .spi_off(soff),
        .wd_miss(wdf), .wd_good(wdg));
    // -----------------------------------------------------------
    // clock, timeout, helpers
    // -----------------------------------------------------------
    initial begin
        forever #2.5 clk = ~clk;
    end
    // a hang costs a mismatch rather than a silent stall
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            mismatches++;
            conclude();
        end
    end
    task automatic chk(input string nm, input logic e, input logic g);
        n_tests++;
        if (g !== e) begin
            mismatches++;
            $display("[FAIL] %s expected %b seen %b", nm, e, g);
        end
    endtask
    task automatic cyc_n(input int n);
        repeat (n) @(negedge clk);
    endtask
    // bounded wait for the main pin to settle, then compare
    task automatic fb_is(input string nm, input logic e);
        for (int i = 0; i < 8 && fn !== e; i++) @(negedge clk);
        chk(nm, e, fn);
    endtask
    // any 200-cycle window holds exact low counts
    task automatic wave();
        int t = 0, d = 0;
        repeat (200) begin
            @(negedge clk);
            t += (tn === 1'b0);
            d += (dn === 1'b0);
        end
        chk("turn low count", 1'b1, t == 100);
        chk("dim low count", 1'b1, d == 40);
        chk("active flag", 1'b1, act);
        chk("pin levels", 1'b0, fo | to | dmo);
    endtask
    // release alone must fail until restart and a good trigger
    task automatic rel_fault();
        md = fbo_pkg::MODE_NORMAL;
        i_mcu.send(2'h1);
        cyc_n(4);
        chk("early release", 1'b0, fn);
        md = fbo_pkg::MODE_RESTART;
        cyc_n(3);
        md = fbo_pkg::MODE_NORMAL;
        i_mcu.send(2'h3);
        cyc_n(4);
        chk("held after trigger", 1'b0, fn);
        i_mcu.send(2'h1);
        fb_is("fault release", 1'b1);
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // -----------------------------------------------------------
    // tests
    // -----------------------------------------------------------
    initial begin
        md = fbo_pkg::MODE_OFF;
        {fb_ok, pwr_ok, cfg2, strap} = 4'hc;
        {rs_s, rs_g, uv, ito, tsd} = 5'h00;
        cyc_n(6);
        nrst = 1'b1;
        cyc_n(3);
        chk("reset pin", 1'b1, fn);
        md = fbo_pkg::MODE_INIT;
        cyc_n(6);
        chk("pull-up in init", 1'b1, pu);
        chk("dim free in init", 1'b1, dn);
        md = fbo_pkg::MODE_NORMAL;
        cyc_n(3);
        chk("dev mode", 1'b1, dev);
        chk("pull-up off", 1'b0, pu);
        chk("normal off", 1'b1, fn);
        $display("end of strap test");
        md = fbo_pkg::MODE_STOP;
        i_mcu.send(2'h0);
        cyc_n(6);
        chk("spi on in stop", 1'b1, fn);
        md = fbo_pkg::MODE_NORMAL;
        i_mcu.send(2'h0);
        fb_is("spi on", 1'b0);
        wave();
        md = fbo_pkg::MODE_SLEEP;
        cyc_n(6);
        chk("kept in sleep", 1'b0, fn);
        fb_ok = 1'b0;
        cyc_n(6);
        chk("low supply", 1'b1, fn);
        fb_ok = 1'b1;
        fb_is("supply back", 1'b0);
        i_mcu.send(2'h1);
        fb_is("spi release", 1'b1);
        cyc_n(2);
        chk("turn idle", 1'b1, tn);
        chk("dim idle", 1'b1, dn);
        chk("active cleared", 1'b0, act);
        $display("end of spi test");
        for (int c = 0; c < 2; c++) begin
            md = fbo_pkg::MODE_NORMAL;
            cfg2 = c[0];
            i_mcu.send(2'h2);
            cyc_n(6);
            chk("one miss", c[0], fn);
            i_mcu.send(2'h2);
            fb_is("two misses", 1'b0);
            rel_fault();
        end
        md = fbo_pkg::MODE_FAIL_SAFE;
        fb_is("fail-safe on", 1'b0);
        md = fbo_pkg::MODE_INIT;
        fb_is("init off", 1'b1);
        ito = 1'b1;
        cyc_n(1);
        ito = 1'b0;
        md = fbo_pkg::MODE_RESTART;
        fb_is("init timeout", 1'b0);
        rel_fault();
        $display("end of mode test");
        for (int k = 0; k < 4; k++) begin
            md = (k == 3) ? fbo_pkg::MODE_SLEEP : fbo_pkg::MODE_RESTART;
            {tsd, uv, rs_g, rs_s} = 4'h1 << k;
            cyc_n(1);
            {tsd, uv, rs_g, rs_s} = 4'h0;
            fb_is("fault source", 1'b0);
            rel_fault();
        end
        $display("end of fault test");
        chk("dev kept", 1'b1, dev);
        pwr_ok = 1'b0;
        cyc_n(6);
        chk("dev cleared", 1'b0, dev);
        // power back with the strap released: no development mode
        {pwr_ok, strap} = 2'h3;
        md = fbo_pkg::MODE_INIT;
        cyc_n(6);
        md = fbo_pkg::MODE_NORMAL;
        cyc_n(3);
        chk("strap high", 1'b0, dev);
        $display("end of power test");
        conclude();
    end
endmodule
